// ==== design/azd_pkg.sv ====
// Constants, field layout and types shared by the zone detector files
`default_nettype none

package azd_pkg;
  localparam int ZONES          = 3;
  localparam int ZONE_TOP       = 2;
  localparam int WIN_LEN        = 10;
  localparam logic [3:0] SAT_ON   = 4'h8;
  localparam logic [3:0] SAT_HOLD = 4'h6;

  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MS_TIME_NS     = 1000000;
  localparam int MS_CYCLES_DEF  = MS_TIME_NS / CLK_PERIOD_NS;
  localparam logic [15:0] MS_PER_S  = 16'h03E8;
  localparam logic [15:0] BPM_MS    = 16'hEA60;
  localparam logic [15:0] TIMER_MAX = 16'hFFFF;

  // Programmable limits
  localparam logic [7:0] RATE_MIN  = 8'h5A;
  localparam logic [7:0] RATE_MAX  = 8'hFA;
  localparam logic [7:0] DUR_MIN   = 8'h01;
  localparam logic [7:0] DUR_TOP   = 8'h0F;
  localparam logic [7:0] DUR_MID   = 8'h1E;
  localparam logic [7:0] DUR_LOW   = 8'h3C;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RATE0  = 8'h04;
  localparam logic [7:0] ADDR_DUR0   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_STEP   = 8'h04;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ZCNT_LSB = 4;
  localparam int ST_SAT_LSB    = 0;
  localparam int ST_EXP_LSB    = 4;
  localparam int ST_MET_BIT    = 8;
  localparam int ST_ZONE_LSB   = 12;
  localparam int ST_LOCK_BIT   = 16;

  // Reset values
  localparam logic [1:0] ZCNT_RESET = 2'h1;
  localparam logic [7:0] RATE_RESET = 8'hA5;
  localparam logic [7:0] DUR_RESET  = 8'h05;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    AZD_OFF,
    AZD_MONITOR,
    AZD_THERAPY
  } azd_mode_type;
endpackage : azd_pkg

`default_nettype wire

// ==== design/azd_zone.sv ====
// One zone: sliding fast/slow window, hysteresis and duration timer
`default_nettype none

module azd_zone
  import azd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        sample,
  input  wire logic        fast,
  input  wire logic        msTick,
  input  wire logic [15:0] durMs,
  output logic             satisfied,
  output logic             expired,
  output logic [3:0]       fastCount
);
  logic [WIN_LEN-1:0] window;
  logic [15:0]        timer;

  function automatic logic [3:0] countFast(input logic [WIN_LEN-1:0] w);
    logic [3:0] c;
    c = 4'h0;
    for (int k = 0; k < WIN_LEN; k++) begin
      c = c + {3'h0, w[k]};
    end
    return c;
  endfunction : countFast

  // Oldest entry falls off, newest enters
  wire [WIN_LEN-1:0] next_window = {window[WIN_LEN-2:0], fast};
  wire [3:0]         next_count  = countFast(next_window);
  wire               next_sat    = satisfied ? (next_count >= SAT_HOLD)
                                             : (next_count >= SAT_ON);
  wire               timerDone   = timer >= durMs;

  // Window state; cleared slots read as slow
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      window    <= '0;
      fastCount <= 4'h0;
      satisfied <= 1'b0;
      expired   <= 1'b0;
    end else if (clear) begin
      window    <= '0;
      fastCount <= 4'h0;
      satisfied <= 1'b0;
      expired   <= 1'b0;
    end else if (sample) begin
      window    <= next_window;
      fastCount <= next_count;
      satisfied <= next_sat;
      // Only checked per interval, so may overrun by up to one interval
      expired   <= next_sat && satisfied && timerDone;
    end
  end

  // Timer sees only this zone's window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer <= 16'h0000;
    end else if (clear || !satisfied || (sample && !next_sat)) begin
      timer <= 16'h0000;
    end else if (msTick && timer != TIMER_MAX) begin
      timer <= timer + 16'h0001;
    end
  end

  // Drop always zeroes the timer
  drop_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(satisfied) |-> timer == 16'h0000)
    else $error("timer not cleared on window drop");

  rise_needs_eight_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(satisfied) |-> fastCount >= SAT_ON)
    else $error("window satisfied below eight fast");

  hold_at_six_a: assert property (@(posedge clk_sys) disable iff (rst)
    ($past(satisfied) && satisfied) |-> fastCount >= SAT_HOLD)
    else $error("window held below six fast");

  expiry_on_sample_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(expired) |-> $past(sample))
    else $error("expiry changed without interval");
endmodule : azd_zone

`default_nettype wire

// ==== design/azd_detector.sv ====
// Zone detector top: AXI4-Lite registers, classification and zone arbitration
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`default_nettype none

module azd_detector
  import azd_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Interval from the sensing front end
  input  wire logic        intervalValid,
  input  wire logic [15:0] intervalMs,
  input  wire logic [2:0]  enhancePass,
  // Result toward charging logic
  output logic             detectMet,
  output logic             chargeReq,
  output logic [1:0]       chargeZone,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // Programmed state
  azd_mode_type mode;
  logic [1:0]   zoneCount;
  logic [7:0]   rateReg [ZONES];
  logic [7:0]   durReg  [ZONES];
  logic         reprogram;

  // Bus holding state
  logic         awHeld;
  logic         wHeld;
  logic [7:0]   awAddr;
  logic [31:0]  wData;
  logic [3:0]   wStrb;

  // Detection state
  logic [31:0]  msCount;
  logic         msTick;
  logic         evalPending;
  logic [2:0]   lastIn;
  logic         chargeLock;
  logic [1:0]   winZone;

  wire [2:0]  sat;
  wire [2:0]  exp;
  wire [2:0]  zoneEn;
  wire [2:0]  fastRaw;
  wire [2:0]  fastVec;
  wire [2:0]  inZone;
  wire [2:0]  met;
  wire [2:0]  win;
  wire [15:0] threshMs [ZONES];
  wire [15:0] durMs    [ZONES];
  wire [3:0]  fastCount [ZONES];

  // Zero zones treated as one; enable counts down from the top zone
  wire [1:0] zoneUse   = (zoneCount == 2'h0) ? 2'h1 : zoneCount;
  wire       modeOff   = (mode == AZD_OFF);
  wire       zoneClear = modeOff || reprogram;

  generate
    for (genvar i = 0; i < ZONES; i++) begin : g_zone
      localparam int RANK = ZONE_TOP - i;
      wire [7:0] rateClamp;
      wire [7:0] durLimit;
      wire [7:0] durClamp;
      wire [15:0] rank;

      assign zoneEn[i] = (32'(zoneUse) + 32'(i)) >= ZONES;
      // Out of range rates are pinned to keep the divide defined
      assign rateClamp = (rateReg[i] < RATE_MIN) ? RATE_MIN :
                         (rateReg[i] > RATE_MAX) ? RATE_MAX : rateReg[i];
      assign threshMs[i] = BPM_MS / {8'h00, rateClamp};
      assign fastRaw[i]  = zoneEn[i] && (intervalMs <= threshMs[i]);
      // Rank counted from the top zone index, not the highest enabled zone, sets the ceiling
      assign durLimit = (RANK == 0) ? DUR_TOP : (RANK == 1) ? DUR_MID : DUR_LOW;
      assign durClamp = (durReg[i] < DUR_MIN) ? DUR_MIN :
                        (durReg[i] > durLimit) ? durLimit : durReg[i];
      assign rank     = {8'h00, durClamp} * MS_PER_S;
      assign durMs[i] = rank;

      if (i == ZONE_TOP) begin : g_top
        assign fastVec[i] = fastRaw[i];
        assign inZone[i]  = fastVec[i];
      end else begin : g_low
        assign fastVec[i] = zoneEn[i] && (fastRaw[i] || fastVec[i+1]);
        assign inZone[i]  = fastVec[i] && !fastVec[i+1];
      end

      // Met only with all four conditions on the latest interval
      assign met[i] = sat[i] && exp[i] && enhancePass[i] && lastIn[i];
      // Any satisfied higher zone masks this one
      assign win[i] = met[i] && !(|(sat >> (i + 1)));

      azd_zone u_zone (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .clear     (zoneClear || !zoneEn[i]),
        .sample    (intervalValid),
        .fast      (fastVec[i]),
        .msTick    (msTick),
        .durMs     (durMs[i]),
        .satisfied (sat[i]),
        .expired   (exp[i]),
        .fastCount (fastCount[i])
      );
    end
  endgenerate

  // Single winner encoded; at most one bit of win is ever set
  wire       anyWin   = |win;
  wire [1:0] next_win = win[2] ? 2'h2 : win[1] ? 2'h1 : 2'h0;

  // Millisecond prescaler shared by all timers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      msCount <= 32'h0000_0000;
      msTick  <= 1'b0;
    end else if (msCount >= 32'(MS_CYCLES - 1)) begin
      msCount <= 32'h0000_0000;
      msTick  <= 1'b1;
    end else begin
      msCount <= msCount + 32'h0000_0001;
      msTick  <= 1'b0;
    end
  end

  // Window state settles one cycle after the interval, then decide
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      evalPending <= 1'b0;
      lastIn      <= 3'h0;
    end else begin
      evalPending <= intervalValid && !modeOff;
      if (intervalValid) begin
        lastIn <= inZone;
      end
    end
  end

  // Decision and charge request; lock holds until all windows drop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      detectMet  <= 1'b0;
      chargeReq  <= 1'b0;
      chargeZone <= 2'h0;
      winZone    <= 2'h0;
      chargeLock <= 1'b0;
    end else begin
      chargeReq <= 1'b0;
      if (modeOff) begin
        detectMet  <= 1'b0;
        chargeLock <= 1'b0;
      end else if (evalPending) begin
        detectMet <= anyWin;
        if (anyWin) begin
          winZone <= next_win;
        end
        if (anyWin && mode == AZD_THERAPY && !chargeLock) begin
          chargeReq  <= 1'b1;
          chargeZone <= next_win;
          chargeLock <= 1'b1;
        end else if (sat == 3'h0) begin
          chargeLock <= 1'b0;
        end
      end
    end
  end

  // Write path decode
  wire       doWrite  = awHeld && wHeld && !s_axi_bvalid;
  wire [7:0] wOff     = awAddr - ADDR_RATE0;
  wire [7:0] dOff     = awAddr - ADDR_DUR0;
  wire       wCtrl    = awAddr == ADDR_CTRL;
  wire       wRate    = awAddr >= ADDR_RATE0 && awAddr < ADDR_DUR0 && awAddr[1:0] == 2'h0;
  wire       wDur     = awAddr >= ADDR_DUR0 && awAddr < ADDR_STATUS && awAddr[1:0] == 2'h0;
  wire       wHit     = wCtrl || wRate || wDur;
  wire [1:0] wIdx     = wOff[3:2];
  wire [1:0] dIdx     = dOff[3:2];

  // Address and data channels taken in either order
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awHeld        <= 1'b0;
      awAddr        <= 8'h00;
      s_axi_awready <= 1'b0;
      wHeld         <= 1'b0;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld        <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end else if (!awHeld) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end else if (!wHeld) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register writes; byte lane 0 carries every field
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode         <= AZD_OFF;
      zoneCount    <= ZCNT_RESET;
      rateReg      <= '{default: RATE_RESET};
      durReg       <= '{default: DUR_RESET};
      reprogram    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      reprogram <= 1'b0;
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wHit ? RESP_OKAY : RESP_SLVERR;
        if (wStrb[0] && wCtrl) begin
          mode      <= azd_mode_type'(wData[CTRL_MODE_LSB +: 2]);
          zoneCount <= wData[CTRL_ZCNT_LSB +: 2];
          reprogram <= 1'b1;
        end
        if (wStrb[0] && wRate && wIdx != 2'h3) begin
          rateReg[wIdx] <= wData[7:0];
          reprogram     <= 1'b1;
        end
        if (wStrb[0] && wDur && dIdx != 2'h3) begin
          durReg[dIdx] <= wData[7:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode
  wire [7:0]  rOffR  = s_axi_araddr - ADDR_RATE0;
  wire [7:0]  rOffD  = s_axi_araddr - ADDR_DUR0;
  wire        rRate  = s_axi_araddr >= ADDR_RATE0 && s_axi_araddr < ADDR_DUR0;
  wire        rDur   = s_axi_araddr >= ADDR_DUR0 && s_axi_araddr < ADDR_STATUS;
  wire        rAlign = s_axi_araddr[1:0] == 2'h0;
  wire [31:0] ctrlWord = {26'h0, zoneCount, 2'h0, mode} ;
  wire [31:0] statWord = {15'h0, chargeLock, 2'h0, winZone, 3'h0, detectMet,
                          1'b0, exp, 1'b0, sat};
  wire        rHit   = rAlign && (s_axi_araddr == ADDR_CTRL || rRate || rDur ||
                                  s_axi_araddr == ADDR_STATUS);
  wire [31:0] next_rdata = !rHit                        ? 32'h0000_0000 :
                           s_axi_araddr == ADDR_CTRL    ? ctrlWord :
                           s_axi_araddr == ADDR_STATUS  ? statWord :
                           rRate ? {24'h0, rateReg[rOffR[3:2]]} :
                                   {24'h0, durReg[rOffD[3:2]]};

  // Read channel; one read outstanding
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= rHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Interval then decision, one cycle apart
  sequence interval_seen_s;
    intervalValid && !modeOff;
  endsequence

  sequence decide_s;
    ##1 evalPending;
  endsequence

  eval_follows_a: assert property (@(posedge clk_sys) disable iff (rst)
    interval_seen_s |-> decide_s)
    else $error("decision not scheduled after interval");

  charge_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(chargeReq) |-> $past(evalPending) && $past(anyWin))
    else $error("charge without met detection");

  charge_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    chargeReq |=> !chargeReq)
    else $error("charge request longer than one cycle");

  monitor_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    (mode != AZD_THERAPY) |=> !chargeReq)
    else $error("charge outside therapy mode");

  off_no_detect_a: assert property (@(posedge clk_sys) disable iff (rst)
    modeOff |=> !detectMet && sat == 3'h0)
    else $error("detection active while off");

  higher_masks_a: assert property (@(posedge clk_sys) disable iff (rst)
    (evalPending && sat[2] && !win[2]) |-> win[1:0] == 2'h0)
    else $error("lower zone won under satisfied higher");

  fast_nested_a: assert property (@(posedge clk_sys) disable iff (rst)
    (fastVec[2] && zoneEn[1]) |-> fastVec[1])
    else $error("higher fast but lower slow");

  bresp_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule : azd_detector

`default_nettype wire

// ==== bench/azd_sense_model.sv ====
// Sensing front end model: hands measured intervals to the detector
`default_nettype none

module azd_sense_model #(
  parameter int GAP = 100
) (
  input  wire logic   clk_sys,
  output logic        intervalValid,
  output logic [15:0] intervalMs
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet bus from time zero
  initial begin
    intervalValid = 1'b0;
    intervalMs    = 16'h0000;
  end

  // n intervals, GAP cycles apart; bus shows the inverse after each pulse so stale data cannot match
  task automatic beats(input int n, input logic [15:0] ms);
    repeat (n) begin
      @(posedge clk_sys);
      intervalValid <= 1'b1;
      intervalMs    <= ms;
      @(posedge clk_sys);
      intervalValid <= 1'b0;
      intervalMs    <= ~ms;
      repeat (GAP - 2) @(posedge clk_sys);
    end
  endtask : beats
endmodule : azd_sense_model

`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking testbench for the zone detector
`default_nettype none

module testbench
  import azd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Interval lengths against zone rates 120/150/200 bpm (500/400/300 ms)
  localparam logic [15:0] IV_TOP  = 16'h00FA;
  localparam logic [15:0] IV_MID  = 16'h015E;
  localparam logic [15:0] IV_SLOW = 16'h0258;
  localparam logic [7:0]  RATES [3] = '{8'h78, 8'h96, 8'hC8};

  logic        clk_sys, rst, intervalValid, detectMet, chargeReq, countClear;
  logic [15:0] intervalMs;
  logic [2:0]  enhancePass;
  logic [1:0]  chargeZone, s_axi_bresp, s_axi_rresp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  int          miscompares, checksDone, chargeCount;

  azd_sense_model #(.GAP(100)) azd_sense_model_i (
    .clk_sys(clk_sys), .intervalValid(intervalValid), .intervalMs(intervalMs));

  // One millisecond per cycle keeps durations short
  azd_detector #(.MS_CYCLES(1)) azd_detector_i (
    .clk_sys(clk_sys), .rst(rst), .intervalValid(intervalValid),
    .intervalMs(intervalMs), .enhancePass(enhancePass), .detectMet(detectMet),
    .chargeReq(chargeReq), .chargeZone(chargeZone),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Charge pulses counted so a scenario can demand exactly one; sole writer of the count
  always @(posedge clk_sys) begin
    if (rst || countClear) chargeCount <= 0;
    else if (chargeReq === 1'b1) chargeCount <= chargeCount + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Valids held until taken; bready stays up until the response
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask : axi_read

  task automatic sat_is(input logic [2:0] e);
    axi_read(ADDR_STATUS, rd, RESP_OKAY);
    check("satisfied", {29'h0, rd[2:0]}, {29'h0, e});
  endtask : sat_is

  // Rates, durations {d2,d1,d0}, then control; control write empties windows
  task automatic cfg(input azd_mode_type m, input logic [1:0] zc, input logic [23:0] durs);
    for (int i = 0; i < ZONES; i++) begin
      axi_write(8'(ADDR_RATE0 + ADDR_STEP * i), {24'h0, RATES[i]}, RESP_OKAY);
      axi_write(8'(ADDR_DUR0 + ADDR_STEP * i), {24'h0, durs[8*i +: 8]}, RESP_OKAY);
    end
    axi_write(ADDR_CTRL, {26'h0, zc, 2'h0, m}, RESP_OKAY);
    countClear <= 1'b1;
    @(posedge clk_sys);
    countClear <= 1'b0;
  endtask : cfg

  task automatic test_regs();
    axi_read(ADDR_CTRL, rd, RESP_OKAY);
    check("ctrl reset", rd, 32'h0000_0010);
    // Byte lane 0 off: the write is answered but must leave the rate alone
    s_axi_wstrb <= 4'hE;
    axi_write(ADDR_RATE0, 32'h0000_0077, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_read(ADDR_RATE0, rd, RESP_OKAY);
    check("rate reset", rd, {24'h0, RATE_RESET});
    axi_read(8'h20, rd, RESP_SLVERR);
    check("unmapped data", rd, 32'h0);
    axi_write(8'h02, 32'h1, RESP_SLVERR);
    axi_write(8'(ADDR_DUR0 + 8'h08), 32'h20, RESP_OKAY);
    axi_read(8'(ADDR_DUR0 + 8'h08), rd, RESP_OKAY);
    check("duration readback", rd, 32'h0000_0020);
    azd_sense_model_i.beats(10, IV_TOP);
    sat_is(3'b000);
    check("charges when off", 32'(chargeCount), 32'd0);
    $display("test regs done");
  endtask : test_regs

  // Eight to set, six to hold, eight again after a drop; timer restarts
  task automatic test_hyst();
    cfg(AZD_MONITOR, 2'h1, {8'h01, 8'h1E, 8'h3C});
    azd_sense_model_i.beats(7, IV_TOP);
    sat_is(3'b000);
    azd_sense_model_i.beats(1, IV_TOP);
    sat_is(3'b100);
    azd_sense_model_i.beats(4, IV_SLOW);
    sat_is(3'b100);
    azd_sense_model_i.beats(1, IV_SLOW);
    sat_is(3'b000);
    azd_sense_model_i.beats(7, IV_TOP);
    sat_is(3'b000);
    azd_sense_model_i.beats(1, IV_TOP);
    sat_is(3'b100);
    azd_sense_model_i.beats(8, IV_TOP);
    check("met before restart ends", {31'h0, detectMet}, 32'h0);
    azd_sense_model_i.beats(3, IV_TOP);
    check("monitor met", {31'h0, detectMet}, 32'h1);
    check("monitor charges", 32'(chargeCount), 32'd0);
    $display("test hysteresis done");
  endtask : test_hyst

  task automatic test_top();
    // Top duration of zero must behave as the one second minimum
    cfg(AZD_THERAPY, 2'h3, {8'h00, 8'h02, 8'h03});
    azd_sense_model_i.beats(16, IV_TOP);
    check("early charge", 32'(chargeCount), 32'd0);
    enhancePass <= 3'h3;
    azd_sense_model_i.beats(4, IV_TOP);
    check("enhance blocks charge", 32'(chargeCount), 32'd0);
    check("enhance blocks met", {31'h0, detectMet}, 32'h0);
    enhancePass <= 3'h7;
    azd_sense_model_i.beats(1, IV_TOP);
    check("charge count", 32'(chargeCount), 32'd1);
    check("charge zone", {30'h0, chargeZone}, 32'h2);
    check("met", {31'h0, detectMet}, 32'h1);
    sat_is(3'b111);
    azd_sense_model_i.beats(10, IV_TOP);
    check("single charge", 32'(chargeCount), 32'd1);
    $display("test top zone done");
  endtask : test_top

  task automatic test_outside();
    cfg(AZD_THERAPY, 2'h1, {8'h01, 8'h1E, 8'h3C});
    azd_sense_model_i.beats(17, IV_TOP);
    azd_sense_model_i.beats(2, IV_SLOW);
    check("withheld", 32'(chargeCount), 32'd0);
    sat_is(3'b100);
    azd_sense_model_i.beats(1, IV_TOP);
    check("back in zone", 32'(chargeCount), 32'd1);
    $display("test outside zone done");
  endtask : test_outside

  // Lower zone expires under a satisfied higher zone, charges once it drops
  task automatic test_lower();
    cfg(AZD_THERAPY, 2'h2, {8'h03, 8'h03, 8'h3C});
    azd_sense_model_i.beats(8, IV_MID);
    azd_sense_model_i.beats(32, IV_TOP);
    check("masked lower", 32'(chargeCount), 32'd0);
    azd_sense_model_i.beats(4, IV_MID);
    check("higher still held", 32'(chargeCount), 32'd0);
    azd_sense_model_i.beats(1, IV_MID);
    check("lower charge", 32'(chargeCount), 32'd1);
    check("lower zone", {30'h0, chargeZone}, 32'h1);
    $display("test lower zone done");
  endtask : test_lower

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : giveVerdict

  // Reset for eight cycles, then the scenarios
  initial begin
    miscompares   = 0;
    checksDone    = 0;
    countClear    = 1'b0;
    rst           = 1'b1;
    enhancePass   = 3'h7;
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hF;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    test_regs();
    test_hyst();
    test_top();
    test_outside();
    test_lower();
    giveVerdict();
  end

  // Hang guard well beyond the roughly 14000 cycles the scenarios need
  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    giveVerdict();
  end
endmodule : testbench

`default_nettype wire
